/* hdl/epmb_pkg.sv */
package epmb_pkg;
  // clock and machine cycle
  localparam int unsigned CLOCK_HZ = 100000000;
  localparam int unsigned CLKS_PER_MC = 4;
  localparam logic [1:0] PH_LAST = 2'h3;
  // reset qualification
  localparam int unsigned RST_MC = 2;
  localparam logic [3:0] RST_CLKS = 4'h8;
  // internal program region
  localparam int unsigned INT_ROM_BYTES = 32768;
  // stretch limits for data moves
  localparam logic [3:0] STRETCH_MIN = 4'h2;
  localparam logic [3:0] STRETCH_MAX = 4'h9;
  localparam logic [3:0] STRETCH_RST = 4'h2;

  typedef enum logic [1:0] {
    EPMB_IDLE = 2'b00,
    EPMB_ADDR = 2'b01,
    EPMB_DATA = 2'b11,
    EPMB_DONE = 2'b10
  } epmb_state_type;

  // request from the core
  typedef struct packed {
    logic valid;
    logic code_read;
    logic data_move;
    logic [15:0] addr;
  } epmb_req_type;

  // bus pins
  typedef struct packed {
    logic addr_latch_strobe;
    logic program_store_strobe_n;
    logic [7:0] low_out;
    logic low_oe_n;
    logic [7:0] high_addr;
  } epmb_pins_type;
endpackage

/* hdl/epmb_bus.sv */
`timescale 1ns/1ps
// Summary of operation
// - select input low forces external fetches; high uses internal program memory below 32 KB
// - select high, non-data access below 32 KB: nothing driven onto bus
// - program store strobe asserted for external fetches and code reads
// - internal fetches and code reads produce no program store strobe
// - address latch strobe lets external latch capture low address byte
// - reset pin high two machine cycles while clock runs resets device
// - each machine cycle is four clocks; bus timing follows it
// - low address byte and data share the low port in time
// - upper address byte driven on the second port
// - data move length programmable from two to nine machine cycles
module epmb_bus (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // pins from outside
  input wire logic i_reset_pin,
  input wire logic i_external_access_select_n,
  input wire logic [7:0] i_low_in,
  // core side
  input wire epmb_pkg::epmb_req_type i_req,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0] i_stretch,
  output logic o_busy,
  output logic o_done,
  output logic o_internal,
  output logic [7:0] o_rdata,
  output logic o_reset,
  // bus pins
  output epmb_pkg::epmb_pins_type o_pins
);
  typedef struct packed {
    logic [1:0] sel_sync;
    logic [1:0] rst_sync;
    logic [3:0] rst_cnt;
    logic reset;
    logic [1:0] phase;
    epmb_pkg::epmb_state_type state;
    logic [3:0] mc_left;
    logic is_data;
    logic busy;
    logic done;
    logic internal;
    logic [7:0] low_sync1;
    logic [7:0] low_sync2;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic [15:0] addr;
    epmb_pkg::epmb_pins_type pins;
  } epmb_reg_type;

  epmb_reg_type r_q;
  epmb_reg_type r_d;
  logic mc_end;
  logic go_internal;
  logic [3:0] len;

  if (epmb_pkg::CLKS_PER_MC != 4) begin
    $error("machine cycle must be four clocks");
  end

  assign mc_end = (r_q.phase == epmb_pkg::PH_LAST);
  assign go_internal = r_q.sel_sync[1] && !i_req.data_move &&
                       (i_req.addr < 16'(epmb_pkg::INT_ROM_BYTES));
  assign len = (i_stretch < epmb_pkg::STRETCH_MIN) ? epmb_pkg::STRETCH_MIN :
               (i_stretch > epmb_pkg::STRETCH_MAX) ? epmb_pkg::STRETCH_MAX : i_stretch;

  always_comb begin
    r_d = r_q;
    r_d.sel_sync = {r_q.sel_sync[0], i_external_access_select_n};
    r_d.rst_sync = {r_q.rst_sync[0], i_reset_pin};
    r_d.low_sync1 = i_low_in;
    r_d.low_sync2 = r_q.low_sync1;
    r_d.done = 1'b0;
    r_d.phase = r_q.phase + 2'h1;
    if (!r_q.rst_sync[1]) begin
      r_d.rst_cnt = 4'h0;
      r_d.reset = 1'b0;
    end else if (r_q.rst_cnt < epmb_pkg::RST_CLKS) begin
      r_d.rst_cnt = r_q.rst_cnt + 4'h1;
    end else begin
      r_d.reset = 1'b1;
    end
    if (r_q.reset) begin
      r_d.state = epmb_pkg::EPMB_IDLE;
      r_d.busy = 1'b0;
      r_d.pins.addr_latch_strobe = 1'b0;
      r_d.pins.program_store_strobe_n = 1'b1;
      r_d.pins.low_oe_n = 1'b1;
    end else begin
      unique case (r_q.state)
        epmb_pkg::EPMB_IDLE: begin
          if (i_req.valid && mc_end) begin
            r_d.busy = 1'b1;
            r_d.addr = i_req.addr;
            r_d.wdata = i_wdata;
            r_d.is_data = i_req.data_move;
            r_d.internal = go_internal;
            r_d.mc_left = i_req.data_move ? len - 4'h1 : 4'h0;
            r_d.state = epmb_pkg::EPMB_ADDR;
            if (!go_internal) begin
              r_d.pins.addr_latch_strobe = 1'b1;
              r_d.pins.low_out = i_req.addr[7:0];
              r_d.pins.low_oe_n = 1'b0;
              r_d.pins.high_addr = i_req.addr[15:8];
            end
          end
        end
        epmb_pkg::EPMB_ADDR: begin
          if (r_q.phase == 2'h1) begin
            // strobe falls while address still driven
            r_d.pins.addr_latch_strobe = 1'b0;
          end
          if (r_q.phase == 2'h2 && !r_q.internal) begin
            r_d.pins.program_store_strobe_n = r_q.is_data;
            r_d.pins.low_out = r_q.wdata;
            r_d.pins.low_oe_n = !r_q.is_data;
          end
          if (mc_end) begin
            r_d.state = (r_q.mc_left == 4'h0) ? epmb_pkg::EPMB_DONE : epmb_pkg::EPMB_DATA;
          end
        end
        epmb_pkg::EPMB_DATA: begin
          if (mc_end) begin
            r_d.mc_left = r_q.mc_left - 4'h1;
            if (r_q.mc_left == 4'h1) begin
              r_d.state = epmb_pkg::EPMB_DONE;
            end
          end
        end
        epmb_pkg::EPMB_DONE: begin
          // strobe kept two more clocks so the port synchroniser holds the byte
          if (r_q.phase == 2'h1) begin
            r_d.rdata = r_q.low_sync2;
            r_d.pins.program_store_strobe_n = 1'b1;
            r_d.pins.low_oe_n = 1'b1;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            r_d.state = epmb_pkg::EPMB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      r_q <= '0;
      r_q.sel_sync <= 2'h3;
      r_q.pins.program_store_strobe_n <= 1'b1;
      r_q.pins.low_oe_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_busy = r_q.busy;
  assign o_done = r_q.done;
  assign o_internal = r_q.internal;
  assign o_rdata = r_q.rdata;
  assign o_reset = r_q.reset;
  assign o_pins = r_q.pins;

  AST_NO_STROBE_INTERNAL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (r_q.state != epmb_pkg::EPMB_IDLE && r_q.internal) |-> r_q.pins.program_store_strobe_n)
    else $error("strobe on internal access");
  AST_QUIET_INTERNAL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (r_q.state != epmb_pkg::EPMB_IDLE && r_q.internal) |->
    (r_q.pins.low_oe_n && !r_q.pins.addr_latch_strobe))
    else $error("bus driven on internal access");
  AST_SELECT_LOW_EXT: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (r_q.state == epmb_pkg::EPMB_IDLE && i_req.valid && mc_end && !r_q.sel_sync[1] && !r_q.reset)
    |=> (!r_q.internal && r_q.pins.addr_latch_strobe))
    else $error("select low fetch not external");
  // latch strobe two clocks wide then falls
  AST_ALE_PULSE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(r_q.pins.addr_latch_strobe) |=>
    r_q.pins.addr_latch_strobe ##1 !r_q.pins.addr_latch_strobe)
    else $error("latch strobe width wrong");
  // code fetch strobes three clocks after latch strobe rises
  AST_PROGRAM_STORE_STROBE_AFTER_ALE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ($rose(r_q.pins.addr_latch_strobe) && !r_q.is_data && !r_q.reset) |=> ##2
    !r_q.pins.program_store_strobe_n)
    else $error("program store strobe missing");
  AST_HIGH_ADDR: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (r_q.busy && !r_q.internal && r_q.state != epmb_pkg::EPMB_ADDR) |->
    (r_q.pins.high_addr == r_q.addr[15:8]))
    else $error("upper address not held");
  // phase advances by one each clock
  AST_PHASE: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    mc_end |=> (r_q.phase == 2'h0) ##3 mc_end)
    else $error("machine cycle not four clocks");
  AST_RESET_QUAL: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!r_q.rst_sync[1] ##1 r_q.rst_sync[1] [*8] ##1 r_q.rst_sync[1]) |=> r_q.reset)
    else $error("reset not entered");
  // low address byte on low port as latch strobe rises
  AST_LOW_ADDR: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $rose(r_q.pins.addr_latch_strobe) |-> (r_q.pins.low_out == r_q.addr[7:0]))
    else $error("low address missing");
  // strobe and port released when the access ends
  AST_STROBE_END: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    r_q.done |-> (r_q.pins.program_store_strobe_n && r_q.pins.low_oe_n))
    else $error("bus not released at end of access");

  COV_EXT_FETCH: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    $fell(r_q.pins.program_store_strobe_n));
  COV_INT_FETCH: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    r_q.done && r_q.internal);
  COV_DATA_MOVE: cover property (@(posedge i_clock) disable iff (!i_arst_n)
    r_q.done && r_q.is_data);
  COV_RESET: cover property (@(posedge i_clock) disable iff (!i_arst_n) $rose(r_q.reset));
endmodule

/* testbench/epmb_rom_model.sv */
`timescale 1ns/1ps
module epmb_rom_model (
  // bus pins from the device
  input wire epmb_pkg::epmb_pins_type i_pins,
  // data back onto the low port
  output logic [7:0] o_low
);
  logic [7:0] lat = 8'h00;
  logic [7:0] held = 8'h00;
  logic [7:0] data;
  always @(negedge i_pins.addr_latch_strobe) lat <= i_pins.low_out;
  assign data = i_pins.high_addr ^ lat ^ 8'h3c;
  // drive only while strobed; released port shows the inverse
  always @(posedge i_pins.program_store_strobe_n) held <= data;
  assign o_low = i_pins.program_store_strobe_n ? ~held : data;
endmodule

/* testbench/test_epmb_bus.sv */
`timescale 1ns/1ps
module test_epmb_bus;
  logic clk = 0;
  logic rst_n = 0;
  logic rpin = 0;
  logic sel_n = 0;
  logic [7:0] low;
  epmb_pkg::epmb_req_type req = '0;
  logic [7:0] wd = 8'ha5;
  logic [3:0] len = 4'h2;
  logic busy, done, intl, rsto;
  logic [7:0] rd;
  epmb_pkg::epmb_pins_type pins;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  epmb_bus u_epmb_bus (.i_clock(clk), .i_arst_n(rst_n), .i_reset_pin(rpin),
    .i_external_access_select_n(sel_n), .i_low_in(low), .i_req(req), .i_wdata(wd),
    .i_stretch(len), .o_busy(busy), .o_done(done), .o_internal(intl), .o_rdata(rd),
    .o_reset(rsto), .o_pins(pins));
  epmb_rom_model u_epmb_rom_model (.i_pins(pins), .o_low(low));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one bus access; n counts cycles from address strobe to done
  task automatic acc(input logic cr, input logic dm, input logic [15:0] a,
      output int n, output logic s, output logic l);
    n = 0;
    s = 1'b0;
    l = 1'b0;
    @(posedge clk);
    req <= '{1'b1, cr, dm, a};
    repeat (200) begin
      @(posedge clk);
      if (busy === 1'b1 || done === 1'b1) req.valid <= 1'b0;
      #1;
      if (pins.addr_latch_strobe === 1'b1 && !l) begin
        chk(pins.low_out, a[7:0], "low_addr");
        chk(pins.high_addr, a[15:8], "high_addr");
      end
      if (pins.addr_latch_strobe === 1'b1) l = 1'b1;
      if (l) n++;
      if (l && done !== 1'b1) chk(busy, 1'b1, "busy");
      if (pins.program_store_strobe_n === 1'b0) begin
        s = 1'b1;
        chk(pins.low_oe_n, 1'b1, "port_released");
      end
      if (l && dm && n > 3 && done !== 1'b1) begin
        chk(pins.low_oe_n, 1'b0, "wdata_drive");
        chk(pins.low_out, wd, "wdata");
      end
      if (done === 1'b1) break;
    end
    chk(done, 1'b1, "done");
  endtask
  task automatic t_ext();
    int n;
    logic s, l;
    sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    acc(1'b0, 1'b0, 16'h0123, n, s, l);
    chk(16'(n), 16'h0007, "fetch_len");
    chk(s, 1'b1, "strobe");
    chk(intl, 1'b0, "internal");
    chk(rd, 8'h01 ^ 8'h23 ^ 8'h3c, "rdata");
  endtask
  task automatic t_int();
    int n;
    logic s, l;
    @(posedge clk);
    sel_n <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b1, 1'b0, 16'h0100, n, s, l);
    chk(s, 1'b0, "no_strobe");
    chk(l, 1'b0, "no_addr");
    chk(intl, 1'b1, "internal");
  endtask
  task automatic t_high();
    int n;
    logic s, l;
    acc(1'b1, 1'b0, 16'h8000, n, s, l);
    chk(s, 1'b1, "strobe");
    chk(l, 1'b1, "addr_out");
    chk(intl, 1'b0, "internal");
    chk(rd, 8'h80 ^ 8'h00 ^ 8'h3c, "code_rdata");
  endtask
  task automatic t_move();
    int n;
    logic s, l;
    for (int v = 1; v <= 10; v++) begin
      @(posedge clk);
      len <= 4'(v);
      acc(1'b0, 1'b1, 16'h4321, n, s, l);
      chk(16'(n), 16'((v < 2 ? 2 : (v > 9 ? 9 : v)) * 4 + 3), "move_len");
    end
  endtask
  task automatic t_rst();
    @(posedge clk);
    rpin <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk(rsto, 1'b0, "early_reset");
    @(posedge clk);
    #1;
    chk(rsto, 1'b1, "reset");
    @(posedge clk);
    rpin <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk(rsto, 1'b0, "reset_off");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_ext();
    t_int();
    t_high();
    t_move();
    t_rst();
    give_verdict();
  end
endmodule
